// [common/esf_pkg.sv]
// constants and helpers shared by the event status flag block
package esf_pkg;

    // ------------------------------------------------------------
    // serial frame layout
    // ------------------------------------------------------------
    localparam int          FRAME_BITS  = 32;
    localparam int          CNT_W       = 6;
    localparam logic [5:0]  FRAME_LEN   = 6'h20;
    localparam logic [5:0]  CNT_MAX     = 6'h3F;
    localparam logic [5:0]  CNT_ZERO    = 6'h00;
    localparam int          FR_WR_BIT   = 31;
    localparam int          FR_ADDR_HI  = 30;
    localparam int          FR_ADDR_LO  = 25;
    localparam int          FR_DATA_HI  = 24;
    localparam int          FR_DATA_LO  = 1;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 6;
    localparam logic [5:0]  ADDR_EVT       = 6'h02;
    localparam logic [5:0]  ADDR_CTRL      = 6'h1A;
    localparam int          CTRL_SWRST_BIT = 0;

    // ------------------------------------------------------------
    // event status register fields
    // ------------------------------------------------------------
    localparam int           EVT_W          = 24;
    localparam int           BIT_FACTORY    = 13;
    localparam int           BIT_CRC        = 8;
    localparam int           BIT_SUPPLY_LOW = 7;
    localparam int           BIT_SUPPLY_HI  = 6;
    localparam int           BIT_TEMP_WARN  = 5;
    localparam int           BIT_THERM_SD   = 4;
    localparam int           BIT_SWITCH     = 3;
    localparam int           BIT_PRTY       = 2;
    localparam int           BIT_FRAME      = 1;
    localparam int           BIT_RESET      = 0;
    localparam logic [23:0]  EVT_RESET      = 24'h000001;
    localparam logic [23:0]  EVT_RC_MASK    = 24'h0021FF;

    // condition vector order
    localparam int COND_N     = 4;
    localparam int COND_LOW   = 0;
    localparam int COND_HIGH  = 1;
    localparam int COND_WARN  = 2;
    localparam int COND_SHUT  = 3;

    // ------------------------------------------------------------
    // response word status positions
    // ------------------------------------------------------------
    localparam int RSP_RESET = 31;
    localparam int RSP_FRAME = 30;
    localparam int RSP_PRTY  = 29;
    localparam int RSP_ANY   = 28;
    localparam int RSP_PAR   = 24;

    typedef enum logic [1:0] {
        ST_LOAD  = 2'b00,
        ST_CHECK = 2'b01,
        ST_RUN   = 2'b11
    } esf_state_e;

    // true when the count of ones is odd
    function automatic logic esf_odd(input logic [31:0] w);
        return ^w;
    endfunction

endpackage

// [rtl/esf_chg_detect.sv]
// synchroniser and change detector for a vector of asynchronous levels
`timescale 1ns/100ps
module esf_chg_detect
    import esf_pkg::*;
#(
    parameter int W = 4
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] level_in,
    output logic      [W-1:0] level_sync,
    output logic      [W-1:0] chg
);

    initial
    begin
        if (W < 1)
            $error("esf_chg_detect: W must be at least 1");
    end

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] prev_r;
    logic         primed_r;
    logic [W-1:0] prev_nxt;
    logic         primed_nxt;

    // ------------------------------------------------------------
    // change detection
    // ------------------------------------------------------------
    // first sample after reset only primes, so a level already high
    // at reset does not count as an event
    always_comb
    begin
        prev_nxt   = s2_r;
        primed_nxt = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        s1_r <= level_in;
        s2_r <= s1_r;
        if (!rst_n)
        begin
            prev_r   <= '0;
            primed_r <= 1'b0;
        end
        else
        begin
            prev_r   <= prev_nxt;
            primed_r <= primed_nxt;
        end
    end

    assign level_sync = s2_r;
    assign chg        = primed_r ? (s2_r ^ prev_r) : '0;

endmodule

// [rtl/esf_spi_link.sv]
// serial link: pin sampling, frame checking and response shifting
`timescale 1ns/100ps
module esf_spi_link
    import esf_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_sdi,
    output logic             spi_sdo,
    output logic             spi_sdo_oe,
    input  wire logic [31:0] tx_word,
    output logic      [31:0] rx_word,
    output logic             rx_ok,
    output logic             rx_par_err,
    output logic             rx_len_err
);

    logic [2:0]  cs_r;
    logic [2:0]  sck_r;
    logic [1:0]  sdi_r;
    logic [31:0] sh_r,  sh_nxt;
    logic [31:0] tx_r,  tx_nxt;
    logic [5:0]  cnt_r, cnt_nxt;
    logic [31:0] rx_word_nxt;
    logic        ok_nxt, perr_nxt, lerr_nxt;
    logic        cs_fall, cs_rise, sck_rise, sck_fall, active;

    // bit 0 of each is the first synchroniser stage, read only by bit 1
    assign active   = !cs_r[1];
    assign cs_fall  = !cs_r[1] && cs_r[2];
    assign cs_rise  = cs_r[1] && !cs_r[2];
    assign sck_rise = active && sck_r[1] && !sck_r[2];
    assign sck_fall = active && !sck_r[1] && sck_r[2];

    // ------------------------------------------------------------
    // frame assembly and check
    // ------------------------------------------------------------
    always_comb
    begin
        sh_nxt      = sh_r;
        tx_nxt      = tx_r;
        cnt_nxt     = cnt_r;
        rx_word_nxt = rx_word;
        ok_nxt      = 1'b0;
        perr_nxt    = 1'b0;
        lerr_nxt    = 1'b0;
        if (cs_fall)
        begin
            cnt_nxt = CNT_ZERO;
            tx_nxt  = tx_word;
        end
        if (sck_rise)
        begin
            sh_nxt = {sh_r[30:0], sdi_r[1]};
            if (cnt_r != CNT_MAX)
                cnt_nxt = cnt_r + 6'h01;
        end
        if (sck_fall)
            tx_nxt = {tx_r[30:0], 1'b0};
        if (cs_rise)
        begin
            if (cnt_r == CNT_ZERO)
                lerr_nxt = 1'b0;
            else if (cnt_r != FRAME_LEN)
                lerr_nxt = 1'b1;
            else if (!esf_odd(sh_r))
                perr_nxt = 1'b1;
            else
            begin
                ok_nxt      = 1'b1;
                rx_word_nxt = sh_r;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        cs_r  <= {cs_r[1:0], spi_cs_n};
        sck_r <= {sck_r[1:0], spi_sclk};
        sdi_r <= {sdi_r[0], spi_sdi};
        if (!rst_n)
        begin
            sh_r       <= '0;
            tx_r       <= '0;
            cnt_r      <= CNT_ZERO;
            rx_word    <= '0;
            rx_ok      <= 1'b0;
            rx_par_err <= 1'b0;
            rx_len_err <= 1'b0;
            spi_sdo_oe <= 1'b0;
        end
        else
        begin
            sh_r       <= sh_nxt;
            tx_r       <= tx_nxt;
            cnt_r      <= cnt_nxt;
            rx_word    <= rx_word_nxt;
            rx_ok      <= ok_nxt;
            rx_par_err <= perr_nxt;
            rx_len_err <= lerr_nxt;
            spi_sdo_oe <= active;
        end
    end

    assign spi_sdo = tx_r[31];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_no_clock_no_error;
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_rise && cnt_r == CNT_ZERO) |=> !rx_len_err && !rx_ok;
    endproperty
    a_no_clock_no_error: assert property (p_no_clock_no_error)
        else $error("frame error raised for a frame with no clock");

    property p_short_long_error;
        @(posedge clk_sys) disable iff (!rst_n)
        (cs_rise && cnt_r != CNT_ZERO && cnt_r != FRAME_LEN) |=> rx_len_err && !rx_ok;
    endproperty
    a_short_long_error: assert property (p_short_long_error)
        else $error("wrong frame length not flagged");

endmodule

// [rtl/esf_event_status.sv]
// event status flag register with serial command port
//
// Overview of operation
// - supply-low flag bit 7 sets when under-voltage starts and when it ends.
// - supply-high flag bit 6 sets when over-voltage starts and when it ends.
// - temperature warning flag bit 5 sets on warning start and on its end.
// - thermal shutdown flag bit 4 sets on shutdown entry and on its clearing.
// - switch-change flag bit 3 sets when any switch input crosses threshold.
// - switch-change flag also sets when first polling cycle after trigger completes.
// - a read command of the event status register clears all its flags.
// - each frame of exactly 32 clocked bits is checked for odd parity; failure sets bit 2.
// - a frame with an even count of ones is discarded unexecuted.
// - the parity flag is mirrored into the response status bits.
// - only exactly 32 clocked bits latch a frame; any other nonzero count sets bit 1.
// - chip select pulsed with no clock does not set the frame error.
// - the frame error flag is mirrored into the response status bits.
// - reset flag bit 0 resets to one and is set by every reset.
// - any reset restores register defaults and restarts the state machine.
// - the reset flag is mirrored into the response status bits.
// - a failed factory load self-check sets bit 13 and the reset flag.
// - completion of a register checksum calculation sets bit 8.
`timescale 1ns/100ps
module esf_event_status
    import esf_pkg::*;
#(
    parameter int SW_NUM = 24
)
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              spi_cs_n,
    input  wire logic              spi_sclk,
    input  wire logic              spi_sdi,
    output logic                   spi_sdo,
    output logic                   spi_sdo_oe,
    input  wire logic              supply_low_cond,
    input  wire logic              supply_high_cond,
    input  wire logic              temp_warn_cond,
    input  wire logic              temp_shutdown_cond,
    input  wire logic [SW_NUM-1:0] switch_input,
    input  wire logic              poll_start,
    input  wire logic              poll_cycle_done,
    input  wire logic              factory_check_fail,
    input  wire logic              crc_done,
    output logic      [EVT_W-1:0]  event_status,
    output logic                   soft_reset,
    output logic                   init_done
);

    initial
    begin
        if (SW_NUM < 1 || SW_NUM > 24)
            $error("esf_event_status: SW_NUM must lie in 1..24");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    esf_state_e         st_r;
    esf_state_e         st_nxt;
    logic [EVT_W-1:0]   evt_r;
    logic [EVT_W-1:0]   evt_nxt;
    logic [EVT_W-1:0]   set_vec;
    logic [EVT_W-1:0]   clr_vec;
    logic               poll_armed_r;
    logic               poll_armed_nxt;
    logic [EVT_W-1:0]   rd_data_r;
    logic [EVT_W-1:0]   rd_data_nxt;
    logic               soft_rst_r;
    logic               soft_rst_nxt;
    logic [31:0]        tx_word;
    logic [31:0]        rx_word;
    logic               rx_ok;
    logic               rx_par_err;
    logic               rx_len_err;
    logic [COND_N-1:0]  cond_in;
    logic [COND_N-1:0]  cond_chg;
    logic [SW_NUM-1:0]  sw_chg;
    logic               cmd_wr;
    logic [ADDR_W-1:0]  cmd_addr;
    logic [EVT_W-1:0]   cmd_data;
    logic               rd_clr;
    logic               any_reset;
    logic [31:0]        rsp_body;

    // ------------------------------------------------------------
    // serial link and event sources
    // ------------------------------------------------------------
    esf_spi_link u_link (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .spi_cs_n   (spi_cs_n),
        .spi_sclk   (spi_sclk),
        .spi_sdi    (spi_sdi),
        .spi_sdo    (spi_sdo),
        .spi_sdo_oe (spi_sdo_oe),
        .tx_word    (tx_word),
        .rx_word    (rx_word),
        .rx_ok      (rx_ok),
        .rx_par_err (rx_par_err),
        .rx_len_err (rx_len_err)
    );

    assign cond_in[COND_LOW]  = supply_low_cond;
    assign cond_in[COND_HIGH] = supply_high_cond;
    assign cond_in[COND_WARN] = temp_warn_cond;
    assign cond_in[COND_SHUT] = temp_shutdown_cond;

    esf_chg_detect #(.W(COND_N)) u_cond (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .level_in   (cond_in),
        .level_sync (),
        .chg        (cond_chg)
    );

    esf_chg_detect #(.W(SW_NUM)) u_sw (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .level_in   (switch_input),
        .level_sync (),
        .chg        (sw_chg)
    );

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // only frames that passed length and parity reach here
    assign cmd_wr    = rx_word[FR_WR_BIT];
    assign cmd_addr  = rx_word[FR_ADDR_HI:FR_ADDR_LO];
    assign cmd_data  = rx_word[FR_DATA_HI:FR_DATA_LO];
    assign any_reset = !rst_n || soft_rst_r;

    always_comb
    begin
        rd_clr = 1'b0;
        if (rx_ok && !cmd_wr && cmd_addr == ADDR_EVT)
            rd_clr = 1'b1;
    end

    // ------------------------------------------------------------
    // init sequence
    // ------------------------------------------------------------
    // state machine restarts
    always_comb
    begin
        case (st_r)
            ST_LOAD:  st_nxt = ST_CHECK;
            ST_CHECK: st_nxt = ST_RUN;
            ST_RUN:   st_nxt = ST_RUN;
            default:  st_nxt = ST_LOAD;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (any_reset)
            st_r <= ST_LOAD;
        else
            st_r <= st_nxt;
    end

    assign init_done = (st_r == ST_RUN);

    // ------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------
    always_comb
    begin
        set_vec = '0;
        set_vec[BIT_SUPPLY_LOW] = cond_chg[COND_LOW];
        set_vec[BIT_SUPPLY_HI]  = cond_chg[COND_HIGH];
        set_vec[BIT_TEMP_WARN]  = cond_chg[COND_WARN];
        set_vec[BIT_THERM_SD]   = cond_chg[COND_SHUT];
        set_vec[BIT_SWITCH]     = (|sw_chg) || (poll_armed_r && poll_cycle_done);
        set_vec[BIT_PRTY]       = rx_par_err;
        set_vec[BIT_FRAME]      = rx_len_err;
        set_vec[BIT_CRC]        = crc_done;
        if (st_r == ST_CHECK && factory_check_fail)
        begin
            set_vec[BIT_FACTORY] = 1'b1;
            set_vec[BIT_RESET]   = 1'b1;
        end
        clr_vec = rd_clr ? EVT_RC_MASK : '0;
        evt_nxt = (evt_r & ~clr_vec) | set_vec;
        poll_armed_nxt = poll_armed_r;
        if (poll_start)
            poll_armed_nxt = 1'b1;
        else if (poll_cycle_done)
            poll_armed_nxt = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (any_reset)
        begin
            evt_r        <= EVT_RESET;
            poll_armed_r <= 1'b0;
        end
        else
        begin
            evt_r        <= evt_nxt;
            poll_armed_r <= poll_armed_nxt;
        end
    end

    assign event_status = evt_r;

    // ------------------------------------------------------------
    // read data and software reset
    // ------------------------------------------------------------
    // unmapped reads return zero; the value shows in the next frame
    always_comb
    begin
        rd_data_nxt  = rd_data_r;
        soft_rst_nxt = 1'b0;
        if (rd_clr)
            rd_data_nxt = evt_r;
        else if (rx_ok && !cmd_wr)
            rd_data_nxt = '0;
        if (rx_ok && cmd_wr && cmd_addr == ADDR_CTRL && cmd_data[CTRL_SWRST_BIT])
            soft_rst_nxt = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rd_data_r  <= '0;
            soft_rst_r <= 1'b0;
        end
        else
        begin
            rd_data_r  <= soft_rst_r ? '0 : rd_data_nxt;
            soft_rst_r <= soft_rst_nxt;
        end
    end

    assign soft_reset = soft_rst_r;

    // ------------------------------------------------------------
    // response word
    // ------------------------------------------------------------
    // status bits are taken live when chip select falls
    always_comb
    begin
        rsp_body = '0;
        rsp_body[RSP_RESET] = evt_r[BIT_RESET];
        rsp_body[RSP_FRAME] = evt_r[BIT_FRAME];
        rsp_body[RSP_PRTY]  = evt_r[BIT_PRTY];
        rsp_body[RSP_ANY]   = |(evt_r & ~EVT_RESET);
        rsp_body[EVT_W-1:0] = rd_data_r;
        // parity bit makes the whole word odd
        tx_word = {rsp_body[31:RSP_PAR+1], !esf_odd(rsp_body), rsp_body[RSP_PAR-1:0]};
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_supply_low_both_edges;
        @(posedge clk_sys) disable iff (any_reset)
        cond_chg[COND_LOW] |=> evt_r[BIT_SUPPLY_LOW];
    endproperty
    a_supply_low_both_edges: assert property (p_supply_low_both_edges)
        else $error("supply-low change did not set its flag");

    property p_supply_high_both_edges;
        @(posedge clk_sys) disable iff (any_reset)
        $changed(supply_high_cond) ##4 (!soft_rst_r) |-> evt_r[BIT_SUPPLY_HI] || $past(rd_clr);
    endproperty
    a_supply_high_both_edges: assert property (p_supply_high_both_edges)
        else $error("supply-high change not flagged within four cycles");

    property p_temp_flags;
        @(posedge clk_sys) disable iff (any_reset)
        (cond_chg[COND_WARN] || cond_chg[COND_SHUT])
            |=> (evt_r[BIT_TEMP_WARN] || !$past(cond_chg[COND_WARN]))
             && (evt_r[BIT_THERM_SD] || !$past(cond_chg[COND_SHUT]));
    endproperty
    a_temp_flags: assert property (p_temp_flags)
        else $error("temperature change did not set its flag");

    property p_switch_change;
        @(posedge clk_sys) disable iff (any_reset)
        (|sw_chg) |=> evt_r[BIT_SWITCH];
    endproperty
    a_switch_change: assert property (p_switch_change)
        else $error("switch crossing did not set the switch flag");

    property p_first_poll;
        @(posedge clk_sys) disable iff (any_reset)
        (poll_armed_r && poll_cycle_done && !poll_start) |=> evt_r[BIT_SWITCH] && !poll_armed_r;
    endproperty
    a_first_poll: assert property (p_first_poll)
        else $error("first poll cycle did not set the switch flag");

    property p_read_clears;
        @(posedge clk_sys) disable iff (any_reset)
        (rd_clr && set_vec == '0) |=> (evt_r == '0) ##1 (rd_data_r == $past(evt_r, 2));
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("clearing read left flags set or returned wrong data");

    property p_set_beats_clear;
        @(posedge clk_sys) disable iff (any_reset)
        (rd_clr && (rx_par_err || crc_done)) |=> evt_r[BIT_PRTY] || evt_r[BIT_CRC];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("event lost against a clearing read");

    property p_mirror_status;
        @(posedge clk_sys) disable iff (any_reset)
        $rose(evt_r[BIT_PRTY]) |-> tx_word[RSP_PRTY] && esf_odd(tx_word);
    endproperty
    a_mirror_status: assert property (p_mirror_status)
        else $error("parity flag not mirrored into response");

    property p_soft_reset_defaults;
        @(posedge clk_sys) disable iff (!rst_n)
        soft_rst_r |=> (evt_r == EVT_RESET) && (st_r == ST_LOAD) ##2 (st_r == ST_RUN);
    endproperty
    a_soft_reset_defaults: assert property (p_soft_reset_defaults)
        else $error("software reset did not restore defaults");

    property p_reset_flag_mirror;
        @(posedge clk_sys) disable iff (!rst_n)
        soft_rst_r |=> evt_r[BIT_RESET] && tx_word[RSP_RESET];
    endproperty
    a_reset_flag_mirror: assert property (p_reset_flag_mirror)
        else $error("reset flag not set after reset");

    property p_factory_fail;
        @(posedge clk_sys) disable iff (any_reset)
        (st_r == ST_CHECK && factory_check_fail) |=> evt_r[BIT_FACTORY] && evt_r[BIT_RESET];
    endproperty
    a_factory_fail: assert property (p_factory_fail)
        else $error("factory check failure not flagged");

    property p_crc_done;
        @(posedge clk_sys) disable iff (any_reset)
        crc_done |=> evt_r[BIT_CRC];
    endproperty
    a_crc_done: assert property (p_crc_done)
        else $error("checksum completion not flagged");

endmodule

// [tb/esf_host_model.sv]
// host controller model driving the serial link
`timescale 1ns/100ps
module esf_host_model
(
    input  wire logic clk_sys,
    output logic      spi_cs_n,
    output logic      spi_sclk,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    initial
    begin
        spi_cs_n = 1'h1;
        spi_sclk = 1'h0;
        spi_sdi  = 1'h0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // host sends n clocks, 32 when legal
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
        r = 32'h0;
        spi_cs_n = 1'h0;
        tk(8);
        for (int i = 0; i < n; i++)
        begin
            spi_sdi = w[31 - (i % 32)];
            tk(4);
            spi_sclk = 1'h1;
            r = {r[30:0], spi_sdo};
            tk(4);
            spi_sclk = 1'h0;
        end
        tk(8);
        spi_cs_n = 1'h1;
        // released data line must not look held
        spi_sdi = ~spi_sdi;
        tk(8);
    endtask
endmodule

// [tb/esf_event_status_tb.sv]
// self-checking bench for the event status flag block
`timescale 1ns/100ps
module esf_event_status_tb import esf_pkg::*;;
    logic        clk_sys = 1'h0, rst_n = 1'h0;
    logic        spi_cs_n, spi_sclk, spi_sdi, spi_sdo, soft_reset, init_done, oe;
    logic [3:0]  cond = 4'h0;
    logic [23:0] sw = 24'h0, ev;
    logic        p_st = 1'h0, p_dn = 1'h0, f_fail = 1'h0, crc = 1'h0;
    logic [31:0] x = 32'h214E, rsp;
    int          errors = 0, tests_run = 0, cyc = 0, k, srst = 0;
    always #10 clk_sys = ~clk_sys;
    esf_event_status #(.SW_NUM(24)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe(oe), .supply_low_cond(cond[0]), .supply_high_cond(cond[1]),
        .temp_warn_cond(cond[2]), .temp_shutdown_cond(cond[3]), .switch_input(sw),
        .poll_start(p_st), .poll_cycle_done(p_dn), .factory_check_fail(f_fail),
        .crc_done(crc), .event_status(ev), .soft_reset(soft_reset), .init_done(init_done));
    esf_host_model host (.clk_sys(clk_sys), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
    function automatic logic [31:0] fr(input logic w, input logic [5:0] a, input logic [23:0] d);
        return {w, a, d, ~^{w, a, d}};
    endfunction
    function automatic logic [23:0] rnd();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x[23:0];
    endfunction
    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic conclude();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd();
        host.xfer(fr(1'h0, ADDR_EVT, rnd()), 32, rsp);
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        tk(1);
        s = 1'h0;
        tk(3);
    endtask
    task automatic ev_is(input logic [23:0] e);
        chk(ev, e);
        rd();
        chk(ev, 24'h0);
        // read data rides in the following frame
        rd();
        chk(rsp[23:0], e);
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            conclude();
        end
    end
    // sampled mid-cycle so the registered pulse has settled
    always @(negedge clk_sys)
        if (soft_reset === 1'h1)
            srst++;
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        tk(3);
        rst_n = 1'h1;
        chk(ev, EVT_RESET);
        chk(oe, 1'h0);
        tk(4);
        chk(init_done, 1'h1);
        rd();
        chk(rsp[RSP_RESET], 1'h1);
        chk(ev, 24'h0);
        for (int i = 0; i < 4; i++)
        begin
            cond[i] = 1'h1;
            tk(8);
            ev_is(24'h80 >> i);
            cond[i] = 1'h0;
            tk(8);
            ev_is(24'h80 >> i);
        end
        for (int i = 0; i < 3; i++)
        begin
            k = rnd() % 24;
            sw[k] = ~sw[k];
            tk(8);
            ev_is(24'h8);
        end
        pulse(p_st);
        chk(ev, 24'h0);
        pulse(p_dn);
        ev_is(24'h8);
        // only the first poll cycle after the trigger counts
        pulse(p_dn);
        chk(ev, 24'h0);
        pulse(crc);
        ev_is(24'h100);
        // corrupt parity on a reset write: must be dropped
        host.xfer(fr(1'h1, ADDR_CTRL, 24'h1) ^ 32'h1, 32, rsp);
        chk(ev, 24'h4);
        rd();
        chk(rsp[RSP_PRTY], 1'h1);
        pulse(crc);
        host.xfer(fr(1'h0, ADDR_EVT, 24'h0), 31, rsp);
        host.xfer(fr(1'h0, ADDR_EVT, 24'h0), 33, rsp);
        chk(ev, 24'h102);
        rd();
        chk(rsp[RSP_FRAME], 1'h1);
        host.xfer(fr(1'h0, ADDR_EVT, 24'h0), 0, rsp);
        chk(ev, 24'h0);
        sw[0] = ~sw[0];
        tk(8);
        // checksum completion lands in the cycle of the clearing read
        fork
            rd();
            begin
                tk(6);
                chk(oe, 1'h1);
                @(posedge spi_cs_n);
                tk(3);
                crc = 1'h1;
                tk(1);
                crc = 1'h0;
            end
        join
        ev_is(24'h100);
        f_fail = 1'h1;
        host.xfer(fr(1'h1, ADDR_CTRL, 24'h1), 32, rsp);
        tk(4);
        f_fail = 1'h0;
        ev_is(24'h2001);
        chk(srst, 32'h1);
        conclude();
    end
endmodule
